// File: pk_const_params.svh
// Constants for the public-key constant routines block
`ifndef PK_CONST_PARAMS_SVH
`define PK_CONST_PARAMS_SVH

`define PK_DIGIT_W        16
`define PK_MAX_DIGITS     64
`define PK_ADDR_W         6
`define PK_SIZE_W         6
`define PK_MIN_MODSIZE    6'h03
`define PK_ENTRY_R2       12'h00C
`define PK_ENTRY_CLEAR    12'h00D
`define PK_ENTRY_W        12
// Register byte offsets
`define PK_OFF_CTRL       12'h000
`define PK_OFF_STATUS     12'h004
`define PK_OFF_ENTRY      12'h008
`define PK_OFF_MEM_ADDR   12'h00C
`define PK_OFF_MEM_DATA   12'h010
`define PK_OFF_CYCLES     12'h014
`define PK_OFF_EST_SEL    12'h018
`define PK_OFF_EST_VAL    12'h01C
// Control field positions
`define PK_CTRL_MODSIZE_LO 0
`define PK_CTRL_EXPSIZE_LO 8
`define PK_CTRL_BFS_BIT    16
`define PK_CTRL_PROJ_BIT   17
`define PK_CTRL_SEL_LO     24
`define PK_CTRL_RESET      32'h0000_0000
// Status bits
`define PK_ST_DONE_BIT     0
`define PK_ST_BUSY_BIT     1
`define PK_ST_ERR_BIT      2

`endif

// File: pk_const_pkg.sv
// Types shared by the public-key constant routines block
package pk_const_pkg;
   typedef logic [15:0] digit_t;
   typedef enum logic [1:0] {MEM_A, MEM_B, MEM_N} mem_sel_e;
   typedef enum {ST_CLEAR, ST_IDLE, ST_LOADN, ST_SEED, ST_DBL, ST_CMP, ST_SUB, ST_STORE,
                 ST_DONE} state_e;
endpackage

// File: pk_digit_ram.sv
// Single-port digit memory with registered read data
`timescale 1ns/1ps
`include "pk_const_params.svh"
module pk_digit_ram (
   input  wire logic                     clock,
   input  wire logic                     we,
   input  wire logic [`PK_ADDR_W-1:0]    addr,
   input  wire logic [`PK_DIGIT_W-1:0]   wdata,
   output logic      [`PK_DIGIT_W-1:0]   rdata
);
   logic [`PK_DIGIT_W-1:0] mem [0:`PK_MAX_DIGITS-1];
   always_ff @(posedge clock) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// File: pk_cycle_est.sv
// Cycle-count formulas of the embedded routines for a given modulus size
`timescale 1ns/1ps
`include "pk_const_params.svh"
module pk_cycle_est (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [`PK_SIZE_W-1:0]  modsize,
   input  wire logic [3:0]             sel,
   output logic      [31:0]            cycles
);
   logic [31:0] ms;
   logic [31:0] sq;
   logic [31:0] mw, mb, mavg4, aw, sw, mv, res;
   always_comb begin
      ms    = {26'h0, modsize} + 32'h1;
      sq    = ms * ms;
      mw    = sq + 32'hA * ms + 32'h1B;
      mb    = sq + 32'h9 * ms + 32'h16;
      // weighted multiply average
      // Weighted 3/4 best, 1/4 worst; kept as four times the average
      mavg4 = 32'h3 * mb + mw;
      aw    = 32'h4 * ms + 32'hB;
      sw    = 32'h3 * ms + 32'hB;
      mv    = ms;
      unique case (sel)
         4'h0: res = mw;
         4'h1: res = mb;
         4'h2: res = 32'h2 * mw;
         4'h3: res = 32'h2 * mb;
         4'h4: res = aw;
         4'h5: res = 32'h3 * ms + 32'h6;
         4'h6: res = sw;
         4'h7: res = 32'h2 * ms + 32'h6;
         4'h8: res = 32'h4 * (ms + 32'h5);
         4'h9: res = mavg4;
         // prime-field point costs
         // Point costs scaled by four because the multiply term is the x4 average
         4'hA: res = 32'h10 * mavg4 + 32'h4 * (32'h4 * aw + 32'h5 * sw + 32'h13 * mv);
         4'hB: res = 32'hA * mavg4 + 32'h4 * (32'hB * aw + 32'h2 * sw + 32'hA * mv);
         4'hC: res = 32'h14 * mavg4 + 32'h4 * (32'h7 * aw + 32'hF * mv);
         4'hD: res = 32'hA * mavg4 + 32'h4 * (32'h4 * aw + 32'h9 * mv);
         default: res = 32'h0;
      endcase
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cycles <= 32'h0;
      end else begin
         cycles <= res;
      end
   end
endmodule

// File: pk_const_routines.sv
// Montgomery constant routines of the public-key engine with APB registers
`timescale 1ns/1ps
`include "pk_const_params.svh"
module pk_const_routines (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr
);
   import pk_const_pkg::*;

   logic [31:0]             ctrl_reg;
   logic [`PK_SIZE_W-1:0]   mem_addr_reg;
   logic [1:0]              mem_bank_reg;
   logic [31:0]             cycles_reg;
   logic [3:0]              est_sel_reg;
   logic                    done_reg;
   logic                    err_reg;
   state_e                  state_reg;
   logic [`PK_SIZE_W-1:0]   idx_reg;
   logic [12:0]             dbl_cnt_reg;
   logic                    ge_reg;
   logic [31:0]             est_cycles;
   // Working value and cached modulus for the doubling loop
   digit_t                  acc_reg [0:`PK_MAX_DIGITS-1];
   digit_t                  nmod_reg [0:`PK_MAX_DIGITS-1];

   wire logic [`PK_SIZE_W-1:0] modsize  = ctrl_reg[`PK_CTRL_MODSIZE_LO +: `PK_SIZE_W];
   wire logic [`PK_SIZE_W-1:0] expsize  = ctrl_reg[`PK_CTRL_EXPSIZE_LO +: `PK_SIZE_W];
   wire logic                  binary_field_select = ctrl_reg[`PK_CTRL_BFS_BIT];
   wire logic                  projective_output_select = ctrl_reg[`PK_CTRL_PROJ_BIT];
   wire logic                  cross_mode = expsize != '0;

   // APB decode; every access completes with no wait states
   wire logic setup_wr = psel && penable && pwrite;
   wire logic acc_rd   = psel && penable && !pwrite;
   wire logic busy     = state_reg != ST_IDLE && state_reg != ST_DONE;
   wire logic mapped   = paddr[11:5] == 7'h0 && paddr[1:0] == 2'h0;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // RAM ports: A, B and N each one instance
   logic                   ram_we  [0:2];
   logic [`PK_ADDR_W-1:0]  ram_adr [0:2];
   digit_t                 ram_wd  [0:2];
   digit_t                 ram_rd  [0:2];
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ram
         pk_digit_ram u_ram (
            .clock (clock),
            .we    (ram_we[g]),
            .addr  (ram_adr[g]),
            .wdata (ram_wd[g]),
            .rdata (ram_rd[g])
         );
      end
   endgenerate

   wire logic host_mem_wr = setup_wr && paddr == `PK_OFF_MEM_DATA && !busy;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ram_we[i]  = 1'b0;
         ram_adr[i] = mem_addr_reg;
         ram_wd[i]  = pwdata[15:0];
      end
      unique case (state_reg)
         ST_CLEAR: begin
            for (int i = 0; i < 3; i++) begin
               ram_we[i]  = 1'b1;
               ram_adr[i] = idx_reg;
               ram_wd[i]  = 16'h0000;
            end
         end
         ST_LOADN: ram_adr[MEM_N] = idx_reg;
         ST_STORE: begin
            ram_we[MEM_B]  = 1'b1;
            ram_adr[MEM_B] = idx_reg;
            ram_wd[MEM_B]  = acc_reg[idx_reg];
         end
         default: begin
            if (host_mem_wr && mem_bank_reg != 2'h3) begin
               ram_we[mem_bank_reg] = 1'b1;
            end
         end
      endcase
   end

   // estimator works on MS = modsize + 1
   pk_cycle_est u_est (
      .clock   (clock),
      .rst_n   (rst_n),
      .modsize (modsize),
      .sel     (est_sel_reg),
      .cycles  (est_cycles)
   );

   // Host registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg     <= `PK_CTRL_RESET;
         mem_addr_reg <= '0;
         mem_bank_reg <= 2'h0;
         est_sel_reg  <= 4'h0;
      end else if (setup_wr && !busy) begin
         unique case (paddr)
            `PK_OFF_CTRL:     ctrl_reg <= pwdata;
            `PK_OFF_MEM_ADDR: begin
               mem_addr_reg <= pwdata[`PK_SIZE_W-1:0];
               mem_bank_reg <= pwdata[9:8];
            end
            `PK_OFF_EST_SEL:  est_sel_reg <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   wire logic start = setup_wr && paddr == `PK_OFF_ENTRY && !busy &&
                      pwdata[11:0] == `PK_ENTRY_R2;
   wire logic clr_start = setup_wr && paddr == `PK_OFF_ENTRY && !busy &&
                          pwdata[11:0] == `PK_ENTRY_CLEAR;
   // Doubling steps: 32D for R^2, 16D + 16E for the cross constant
   wire logic [12:0] dbl_total = cross_mode ?
         13'({modsize, 4'h0} + {expsize, 4'h0} + 13'h20) : 13'({modsize, 5'h00} + 13'h20);

   // Routine sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= ST_CLEAR;
         idx_reg     <= '0;
         dbl_cnt_reg <= 13'h0;
         done_reg    <= 1'b0;
         err_reg     <= 1'b0;
         cycles_reg  <= 32'h0;
      end else begin
         if (busy) begin
            cycles_reg <= cycles_reg + 32'h1;
         end
         unique case (state_reg)
            // clear spans whole memory then done
            ST_CLEAR: begin
               idx_reg <= idx_reg + 1'b1;
               if (idx_reg == `PK_SIZE_W'(`PK_MAX_DIGITS - 1)) begin
                  state_reg <= ST_DONE;
                  done_reg  <= 1'b1;
               end
            end
            ST_IDLE, ST_DONE: begin
               if (start) begin
                  done_reg   <= 1'b0;
                  cycles_reg <= 32'h0;
                  // Binary-field or undersized runs are refused and flagged
                  if (binary_field_select || modsize < `PK_MIN_MODSIZE) begin
                     err_reg   <= 1'b1;
                     done_reg  <= 1'b1;
                     state_reg <= ST_DONE;
                  end else begin
                     err_reg   <= 1'b0;
                     idx_reg   <= '0;
                     state_reg <= ST_LOADN;
                  end
               end else if (clr_start) begin
                  done_reg   <= 1'b0;
                  idx_reg    <= '0;
                  cycles_reg <= 32'h0;
                  state_reg  <= ST_CLEAR;
               end
            end
            // Read data lags address by one cycle
            ST_LOADN: begin
               idx_reg <= idx_reg + 1'b1;
               if (idx_reg == modsize + 1'b1) begin
                  state_reg <= ST_SEED;
               end
            end
            ST_SEED: begin
               dbl_cnt_reg <= 13'h0;
               idx_reg     <= '0;
               state_reg   <= ST_DBL;
            end
            ST_DBL: begin
               state_reg <= ST_CMP;
            end
            ST_CMP: begin
               state_reg <= ge_reg ? ST_SUB : ST_DBL;
               if (!ge_reg) begin
                  dbl_cnt_reg <= dbl_cnt_reg + 13'h1;
                  if (dbl_cnt_reg + 13'h1 == dbl_total) begin
                     state_reg <= ST_STORE;
                     idx_reg   <= '0;
                  end
               end
            end
            ST_SUB: begin
               state_reg <= ST_CMP;
            end
            ST_STORE: begin
               idx_reg <= idx_reg + 1'b1;
               if (idx_reg == modsize) begin
                  state_reg <= ST_DONE;
                  done_reg  <= 1'b1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Whole-vector arithmetic done in one cycle per pass for compactness
   logic [`PK_MAX_DIGITS*16:0] acc_flat, n_flat;
   always_comb begin
      acc_flat = '0;
      n_flat   = '0;
      for (int i = 0; i < `PK_MAX_DIGITS; i++) begin
         if (i <= modsize) begin
            acc_flat[i*16 +: 16] = acc_reg[i];
            n_flat[i*16 +: 16]   = nmod_reg[i];
         end
      end
   end

   // value kept below N between doublings
   always_ff @(posedge clock) begin
      unique case (state_reg)
         ST_LOADN: begin
            if (idx_reg != '0) begin
               nmod_reg[idx_reg - 1'b1] <= ram_rd[MEM_N];
            end
         end
         ST_SEED: begin
            for (int i = 0; i < `PK_MAX_DIGITS; i++) begin
               acc_reg[i] <= (i == 0) ? 16'h0001 : 16'h0000;
            end
         end
         // extra 16E doublings give the cross constant
         ST_DBL: begin
            for (int i = 0; i < `PK_MAX_DIGITS; i++) begin
               acc_reg[i] <= 16'((acc_flat << 1) >> (i*16));
            end
            ge_reg <= ((acc_flat << 1) >> ((modsize + 1) * 16)) != '0 ||
                      ((acc_flat << 1) & ~({(`PK_MAX_DIGITS*16+1){1'b1}} <<
                       ((modsize + 1) * 16))) >= n_flat;
         end
         ST_SUB: begin
            for (int i = 0; i < `PK_MAX_DIGITS; i++) begin
               acc_reg[i] <= 16'((acc_flat - n_flat) >> (i*16));
            end
            ge_reg <= 1'b0;
         end
         default: ;
      endcase
   end

   // Read mux shows engine state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata      <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `PK_OFF_CTRL:     prdata <= ctrl_reg;
            `PK_OFF_STATUS:   prdata <= {29'h0, err_reg, busy, done_reg};
            `PK_OFF_ENTRY:    prdata <= 32'h0;
            `PK_OFF_MEM_ADDR: prdata <= {22'h0, mem_bank_reg, 2'h0, mem_addr_reg};
            `PK_OFF_MEM_DATA: prdata <= {16'h0, ram_rd[mem_bank_reg == 2'h3 ? 2'h0 : mem_bank_reg]};
            `PK_OFF_CYCLES:   prdata <= cycles_reg;
            `PK_OFF_EST_SEL:  prdata <= {28'h0, est_sel_reg};
            `PK_OFF_EST_VAL:  prdata <= est_cycles;
            default:          prdata <= 32'h0;
         endcase
      end
   end

   // timing assumes projective mode; bit only stored for host use
   wire logic unused_proj = projective_output_select;

   property p_clear_after_reset;
      @(posedge clock) disable iff (!rst_n)
      $rose(done_reg) && $past(state_reg) == ST_CLEAR |-> ram_we[MEM_A] == 1'b0;
   endproperty
   a_clear_after_reset: assert property (p_clear_after_reset) else $error("clear overran");

   property p_refuse_bfs;
      @(posedge clock) disable iff (!rst_n)
      start && binary_field_select |=> err_reg && state_reg == ST_DONE;
   endproperty
   a_refuse_bfs: assert property (p_refuse_bfs) else $error("binary field not refused");

   property p_below_mod;
      @(posedge clock) disable iff (!rst_n)
      state_reg == ST_STORE |-> acc_flat < n_flat;
   endproperty
   a_below_mod: assert property (p_below_mod) else $error("result not reduced");

   property p_n_kept;
      @(posedge clock) disable iff (!rst_n)
      busy && state_reg != ST_CLEAR |-> !ram_we[MEM_N] && !ram_we[MEM_A];
   endproperty
   a_n_kept: assert property (p_n_kept) else $error("N or A written by routine");
   property p_dbl_count;
      @(posedge clock) disable iff (!rst_n)
      state_reg == ST_STORE && $past(state_reg) == ST_CMP |-> dbl_cnt_reg == dbl_total;
   endproperty
   a_dbl_count: assert property (p_dbl_count) else $error("wrong doubling count");
   property p_clear_zeroes;
      @(posedge clock) disable iff (!rst_n)
      state_reg == ST_CLEAR |-> ram_we[MEM_A] && ram_we[MEM_B] && ram_we[MEM_N] && ram_wd[MEM_N] == 16'h0000;
   endproperty
   a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear not writing zero");
endmodule

// File: pk_host_model.sv
// APB host model that loads operands and launches the constant routines
`timescale 1ns/1ps
`include "pk_const_params.svh"
module pk_host_model (
   input  wire logic         clock,
   output logic              psel,
   output logic              penable,
   output logic              pwrite,
   output logic      [11:0]  paddr,
   output logic      [31:0]  pwdata,
   input  wire logic [31:0]  prdata,
   input  wire logic         pready,
   input  wire logic         pslverr
);
   logic [31:0] rd_data;
   logic        rd_err;
   logic [15:0] kept [64];

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end

   // A free cycle always follows, so a data read after an address write is never stale
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= data;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~data;
   endtask

   task automatic digit_write(input logic [1:0] bank, input logic [5:0] idx,
                              input logic [15:0] d);
      xfer(1'b1, `PK_OFF_MEM_ADDR, {22'h0, bank, 2'h0, idx});
      xfer(1'b1, `PK_OFF_MEM_DATA, {16'h0, d});
   endtask

   task automatic digit_read(input logic [1:0] bank, input logic [5:0] idx,
                             output logic [15:0] d);
      xfer(1'b1, `PK_OFF_MEM_ADDR, {22'h0, bank, 2'h0, idx});
      xfer(1'b0, `PK_OFF_MEM_DATA, 32'h0);
      d = rd_data[15:0];
   endtask

   task automatic set_ctrl(input logic [5:0] msz, input logic [5:0] esz, input logic bfs);
      xfer(1'b1, `PK_OFF_CTRL, {14'h0, 1'b1, bfs, 2'h0, esz, 2'h0, msz});
   endtask

   // sizes set first; callers keep four digits and D + 4 < E
   task automatic start_routine(input logic [5:0] msz, input logic [5:0] esz, input logic bfs,
                                input logic [11:0] entry);
      set_ctrl(msz, esz, bfs);
      xfer(1'b1, `PK_OFF_ENTRY, {20'h0, entry});
   endtask

   task automatic wait_done();
      do xfer(1'b0, `PK_OFF_STATUS, 32'h0);
      while (rd_data[`PK_ST_BUSY_BIT] !== 1'b0 || rd_data[`PK_ST_DONE_BIT] !== 1'b1);
   endtask

   // slow constant read once and kept
   task automatic fetch_result(input logic [1:0] bank, input int count);
      for (int i = 0; i < count; i++) digit_read(bank, 6'(i), kept[i]);
   endtask
endmodule

// File: tb_pk_const_routines.sv
// Self-checking bench for the public-key constant routines block
`timescale 1ns/1ps
`include "pk_const_params.svh"
module tb_pk_const_routines;
   typedef struct {
      logic [5:0]  msz;
      logic [3:0]  sel;
      logic [31:0] exp_val;
   } est_row_s;

   logic          clock;
   logic          rst_n;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [11:0]   paddr;
   logic [31:0]   pwdata;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   int            fails = 0;
   int            total_checks = 0;
   est_row_s      rows [42];
   logic [1023:0] modulus;
   logic [1023:0] want;
   logic [15:0]   dig;
   logic [5:0]    msz_v;
   logic [5:0]    esz_v;
   int            nbits;

   pk_const_routines dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
                          .prdata, .pready, .pslverr);
   pk_host_model host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                       .pready, .pslverr);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_flag(input string what, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Seed of one doubled and reduced n times
   function automatic logic [1023:0] pow2_mod(input int n, input logic [1023:0] m);
      logic [1024:0] r;
      r = 1025'd1;
      for (int i = 0; i < n; i++) begin
         r = r << 1;
         if (r >= {1'b0, m}) r = r - {1'b0, m};
      end
      return r[1023:0];
   endfunction

   function automatic logic [31:0] est_expect(input int ms, input int sel);
      int wm;
      int bm;
      int a4;
      int aw;
      int sw;
      wm = ms * ms + 10 * ms + 27;
      bm = ms * ms + 9 * ms + 22;
      a4 = 3 * bm + wm;
      aw = 4 * ms + 11;
      sw = 3 * ms + 11;
      case (sel)
         0: return 32'(wm);
         1: return 32'(bm);
         2: return 32'(2 * wm);
         3: return 32'(2 * bm);
         4: return 32'(4 * ms + 11);
         5: return 32'(3 * ms + 6);
         6: return 32'(3 * ms + 11);
         7: return 32'(2 * ms + 6);
         8: return 32'(4 * (ms + 5));
         9: return 32'(a4);
         10: return 32'(16 * a4 + 4 * (4 * aw + 5 * sw + 19 * ms));
         11: return 32'(10 * a4 + 4 * (11 * aw + 2 * sw + 10 * ms));
         12: return 32'(20 * a4 + 4 * (7 * aw + 15 * ms));
         default: return 32'(10 * a4 + 4 * (4 * aw + 9 * ms));
      endcase
   endfunction

   // Generous against some two thousand cycles of expected traffic
   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      host.wait_done();
      host.xfer(1'b0, `PK_OFF_CTRL, 32'h0);
      check_word("control reset", `PK_CTRL_RESET, host.rd_data);
      for (int b = 0; b < 3; b++) begin
         for (int k = 0; k < 2; k++) begin
            host.digit_read(2'(b), k ? 6'h3F : 6'h00, dig);
            check_word("cleared digit", 32'h0, {16'h0, dig});
         end
      end
      $display("test reset clear done");
      for (int i = 0; i < 42; i++) begin
         rows[i].msz = (i < 14) ? 6'h00 : ((i < 28) ? 6'h03 : 6'h3F);
         rows[i].sel = 4'(i % 14);
         rows[i].exp_val = est_expect(int'(rows[i].msz) + 1, i % 14);
      end
      foreach (rows[i]) begin
         host.set_ctrl(rows[i].msz, 6'h00, 1'b0);
         host.xfer(1'b1, `PK_OFF_EST_SEL, {28'h0, rows[i].sel});
         host.xfer(1'b0, `PK_OFF_EST_VAL, 32'h0);
         check_word("run time", rows[i].exp_val, host.rd_data);
      end
      $display("test run time table done");
      for (int c = 0; c < 2; c++) begin
         msz_v = c ? 6'h04 : 6'h03;
         esz_v = c ? 6'h09 : 6'h00;
         modulus = '0;
         for (int i = 0; i <= int'(msz_v); i++) begin
            dig = 16'h8001 + 16'(i) * 16'h0123;
            modulus[16*i +: 16] = dig;
            host.digit_write(2'h2, 6'(i), dig);
         end
         nbits = 16 * (int'(msz_v) + 1) + 16 * (int'(c ? esz_v : msz_v) + 1);
         want = pow2_mod(nbits, modulus);
         host.start_routine(msz_v, esz_v, 1'b0, `PK_ENTRY_R2);
         host.wait_done();
         check_flag("error flag", 1'b0, host.rd_data[`PK_ST_ERR_BIT]);
         host.fetch_result(2'h1, int'(msz_v) + 1);
         for (int i = 0; i <= int'(msz_v); i++) begin
            check_word("result digit", {16'h0, want[16*i +: 16]}, {16'h0, host.kept[i]});
            host.digit_read(2'h2, 6'(i), dig);
            check_word("modulus digit", {16'h0, modulus[16*i +: 16]}, {16'h0, dig});
         end
         $display("test constant routine %0d done", c);
      end
      for (int c = 0; c < 2; c++) begin
         host.start_routine(c ? 6'h02 : 6'h03, 6'h00, c ? 1'b0 : 1'b1, `PK_ENTRY_R2);
         host.wait_done();
         check_flag("refused start", 1'b1, host.rd_data[`PK_ST_ERR_BIT]);
      end
      $display("test refused starts done");
      host.xfer(1'b0, 12'h020, 32'h0);
      check_flag("unmapped error", 1'b1, host.rd_err);
      host.xfer(1'b0, 12'h006, 32'h0);
      check_flag("unaligned error", 1'b1, host.rd_err);
      host.xfer(1'b0, `PK_OFF_STATUS, 32'h0);
      check_flag("mapped error", 1'b0, host.rd_err);
      $display("test address decode done");
      host.start_routine(6'h03, 6'h00, 1'b0, `PK_ENTRY_CLEAR);
      host.wait_done();
      for (int b = 1; b < 3; b++) begin
         host.digit_read(2'(b), 6'h00, dig);
         check_word("cleared again", 32'h0, {16'h0, dig});
      end
      $display("test clear entry done");
      host.digit_write(2'h1, 6'h00, 16'h5A5A);
      host.start_routine(6'h03, 6'h00, 1'b0, `PK_ENTRY_R2);
      rst_n <= 1'b0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      host.wait_done();
      host.xfer(1'b0, `PK_OFF_CTRL, 32'h0);
      check_word("control after reset", `PK_CTRL_RESET, host.rd_data);
      host.digit_read(2'h1, 6'h00, dig);
      check_word("cleared after reset", 32'h0, {16'h0, dig});
      $display("test reset in run done");
      give_verdict();
   end
endmodule
